// [hw/iplk_pkg.sv]
package iplk_pkg;
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          PAGE_BYTES      = 16;
    localparam int          CODE_W          = 12;
    localparam int          ID_CODE_BYTES   = 3;
    localparam int          ADDR_TOP_BIT    = 7;
    localparam int          SEAL_DATA_BIT   = 1;
    localparam int          LOCK_STATUS_BIT = 0;
    localparam logic [7:0]  SHIPPED_BYTE    = 8'hFF;
    localparam logic [1:0]  BP_ALL          = 2'h3;
    localparam logic [2:0]  HSIZE_WORD      = 3'h2;
    localparam int          HTRANS_ACT_BIT  = 1;
    // register byte offsets
    localparam logic [7:0]  ADDR_CTRL       = 8'h00;
    localparam logic [7:0]  ADDR_STAT       = 8'h04;
    localparam logic [7:0]  ADDR_FAULT      = 8'h08;
    // control / status / fault field positions
    localparam int          CTRL_WL_BIT     = 0;
    localparam int          CTRL_BPLO_BIT   = 1;
    localparam int          CTRL_BPHI_BIT   = 2;
    localparam int          STAT_WL_BIT     = 0;
    localparam int          STAT_WA_BIT     = 1;
    localparam int          STAT_LOCK_BIT   = 2;
    localparam int          STAT_BPLO_BIT   = 4;
    localparam int          STAT_BPHI_BIT   = 5;
    localparam int          STAT_FIX_BIT    = 6;
    localparam int          FAULT_IDX_LSB   = 0;
    localparam int          FAULT_BIT_LSB   = 4;

    typedef enum logic [2:0] {
        LNK_IDLE, LNK_OPCODE, LNK_ADDR, LNK_WDATA, LNK_RDOUT, LNK_SKIP
    } iplk_link_e;

    // single-error-correcting code over one byte; all-zero byte codes to zero
    function automatic logic [CODE_W-1:0] ecc_enc(input logic [7:0] d);
        return {d[7], d[6], d[5], d[4], d[7] ^ d[6] ^ d[5] ^ d[4],
                d[3], d[2], d[1], d[3] ^ d[2] ^ d[1] ^ d[7],
                d[0], d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6],
                d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6]};
    endfunction

    // returns {corrected, data}
    function automatic logic [8:0] ecc_dec(input logic [CODE_W-1:0] c);
        logic [3:0]        syn;
        logic [CODE_W-1:0] f;
        syn = 4'h0;
        f   = c;
        for (int i = 1; i <= CODE_W; i++) begin
            if (c[i-1]) begin
                syn = syn ^ 4'(i);
            end
        end
        if (syn != 4'h0 && syn <= 4'(CODE_W)) begin
            f[syn - 4'h1] = ~f[syn - 4'h1];
        end
        return {syn != 4'h0, f[11], f[10], f[9], f[8], f[6], f[5], f[4], f[2]};
    endfunction
endpackage

// [hw/iplk_top.sv]
// Overview of operation
// R1 - id write: opcode, address, data bytes
// R2 - id write decodes only low four address bits
// R3 - cs rise starts timed write cycle
// R4 - drop write/seal when busy, protected, unlatched
// R5 - lock read needs top address bit set
// R6 - lock byte lsb shows lock state
// R7 - lock byte repeats while selected
// R8 - lock read ignored during write cycle
// R9 - master ends lock read by deselecting
// R10 - seal needs top address bit, data bit1
// R11 - seal only on byte-boundary deselect
// R12 - valid seal starts timed write cycle
// R13 - sealed page stays read-only forever
// R14 - power-on clear ignores link commands
// R15 - after clear: idle, flags zero, levels kept
// R16 - master powers down idle and deselected
// R17 - deselected device floats serial output
// R18 - reads correct single flipped bit per byte
// R19 - shipped: bytes FFh, levels zero, id code
// R20 - erase clears to zero, then program
// R21 - opcodes and program time are parameters
`timescale 1ns/100ps
`default_nettype none
module iplk_top #(
    parameter int          PROGRAM_TIME_US = 5,
    parameter logic [7:0]  WRITE_OP        = 8'hA2,
    parameter logic [7:0]  READ_OP         = 8'hA3,
    parameter logic [23:0] ID_CODE         = 24'h5A_5AC3 // arbitrary value
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        nv_resetn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic        hreadyout,
    output var  logic        hresp,
    output var  logic [31:0] hrdata,
    input  wire logic        spi_s_n,
    input  wire logic        spi_c,
    input  wire logic        spi_d,
    output var  logic        spi_q,
    output var  logic        spi_q_oe
);
    localparam int PROG_CYCLES = (PROGRAM_TIME_US * 1000
                                  + iplk_pkg::CLK_PERIOD_NS - 1)
                                 / iplk_pkg::CLK_PERIOD_NS; // R21
    localparam int TW_W = $clog2(PROG_CYCLES + 1);

    if (PROG_CYCLES < 2 || WRITE_OP == READ_OP) begin : g_bad_param
        $error("program time too short or opcodes equal");
    end

    // link input synchronisers; stage 0 is read only by stage 1
    logic [1:0] s_sy_q, c_sy_q, d_sy_q;
    logic       s_prev_q, c_prev_q;
    logic       s_rise, s_fall, c_rise, c_fall;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_sy_q   <= 2'h3;
            c_sy_q   <= 2'h0;
            d_sy_q   <= 2'h0;
            s_prev_q <= 1'b1;
            c_prev_q <= 1'b0;
        end else if (ce) begin
            s_sy_q   <= {s_sy_q[0], spi_s_n};
            c_sy_q   <= {c_sy_q[0], spi_c};
            d_sy_q   <= {d_sy_q[0], spi_d};
            s_prev_q <= s_sy_q[1];
            c_prev_q <= c_sy_q[1];
        end
    end

    assign s_rise = s_sy_q[1] & ~s_prev_q;
    assign s_fall = ~s_sy_q[1] & s_prev_q;
    assign c_rise = c_sy_q[1] & ~c_prev_q;
    assign c_fall = ~c_sy_q[1] & c_prev_q;

    iplk_pkg::iplk_link_e st_q;
    logic [2:0]  bit_cnt_q, ocnt_q;
    logic [7:0]  sh_q, addr_q, obyte_q;
    logic        is_rd_q, any_data_q, seal_ok_q;
    logic [3:0]  ptr_q, oaddr_q;
    logic [7:0]  wbuf_q [iplk_pkg::PAGE_BYTES];
    logic [iplk_pkg::PAGE_BYTES-1:0] wmask_q;
    logic [iplk_pkg::CODE_W-1:0]     mem_q [iplk_pkg::PAGE_BYTES];
    logic        locked_q, wl_q, wa_q, seal_q, fix_q;
    logic [1:0]  bp_q;
    logic [TW_W-1:0] tw_cnt_q;

    logic [7:0]  byte_in, lock_byte, out_next;
    logic [3:0]  rd_idx;
    logic [8:0]  rd_dec;
    logic        first_load, next_load, load_lock, fix_evt;
    logic        start_ok, tw_done;

    always_comb begin
        byte_in   = {sh_q[6:0], d_sy_q[1]};
        lock_byte = 8'h00;
        lock_byte[iplk_pkg::LOCK_STATUS_BIT] = locked_q; // R6
        first_load = c_rise && !s_sy_q[1] && st_q == iplk_pkg::LNK_ADDR
                     && bit_cnt_q == 3'h7 && is_rd_q && !wa_q;
        next_load  = c_fall && !s_sy_q[1] && st_q == iplk_pkg::LNK_RDOUT
                     && ocnt_q == 3'h7;
        load_lock  = first_load ? byte_in[iplk_pkg::ADDR_TOP_BIT]
                                : addr_q[iplk_pkg::ADDR_TOP_BIT]; // R5
        rd_idx     = first_load ? byte_in[3:0] : oaddr_q;
        rd_dec     = iplk_pkg::ecc_dec(mem_q[rd_idx]); // R18
        out_next   = load_lock ? lock_byte : rd_dec[7:0]; // R7
        fix_evt    = (first_load || next_load) && !load_lock && rd_dec[8];
    end

    // link command decode and shifting
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin // R14
            st_q       <= iplk_pkg::LNK_IDLE;
            bit_cnt_q  <= 3'h0;
            ocnt_q     <= 3'h0;
            sh_q       <= 8'h00;
            addr_q     <= 8'h00;
            obyte_q    <= 8'h00;
            is_rd_q    <= 1'b0;
            any_data_q <= 1'b0;
            seal_ok_q  <= 1'b0;
            ptr_q      <= 4'h0;
            oaddr_q    <= 4'h0;
            wmask_q    <= '0;
            for (int i = 0; i < iplk_pkg::PAGE_BYTES; i++) begin
                wbuf_q[i] <= 8'h00;
            end
        end else if (ce) begin
            if (s_sy_q[1]) begin
                st_q <= iplk_pkg::LNK_IDLE;
            end else if (s_fall) begin // R1
                st_q       <= iplk_pkg::LNK_OPCODE;
                bit_cnt_q  <= 3'h0;
                any_data_q <= 1'b0;
                seal_ok_q  <= 1'b0;
                if (!wa_q) begin
                    wmask_q <= '0;
                end
            end else if (c_rise && (st_q == iplk_pkg::LNK_OPCODE
                                    || st_q == iplk_pkg::LNK_ADDR
                                    || st_q == iplk_pkg::LNK_WDATA)) begin
                sh_q      <= byte_in;
                bit_cnt_q <= bit_cnt_q + 3'h1;
                if (bit_cnt_q == 3'h7) begin
                    unique case (st_q)
                        iplk_pkg::LNK_OPCODE: begin
                            is_rd_q <= byte_in == READ_OP;
                            if (byte_in == WRITE_OP || byte_in == READ_OP) begin
                                st_q <= iplk_pkg::LNK_ADDR;
                            end else begin
                                st_q <= iplk_pkg::LNK_SKIP;
                            end
                        end
                        iplk_pkg::LNK_ADDR: begin
                            addr_q  <= byte_in;
                            ptr_q   <= byte_in[3:0]; // R2
                            oaddr_q <= byte_in[3:0] + 4'h1;
                            ocnt_q  <= 3'h0;
                            obyte_q <= out_next;
                            if (!is_rd_q) begin
                                st_q <= iplk_pkg::LNK_WDATA;
                            end else if (wa_q) begin
                                st_q <= iplk_pkg::LNK_SKIP; // R8
                            end else begin
                                st_q <= iplk_pkg::LNK_RDOUT;
                            end
                        end
                        iplk_pkg::LNK_WDATA: begin
                            any_data_q <= 1'b1;
                            if (addr_q[iplk_pkg::ADDR_TOP_BIT]) begin
                                seal_ok_q <= byte_in[iplk_pkg::SEAL_DATA_BIT]; // R10
                            end else if (!wa_q) begin
                                // page wraps; later bytes overwrite earlier
                                wbuf_q[ptr_q]  <= byte_in;
                                wmask_q[ptr_q] <= 1'b1;
                                ptr_q          <= ptr_q + 4'h1;
                            end
                        end
                        default: st_q <= iplk_pkg::LNK_SKIP;
                    endcase
                end
            end else if (c_fall && st_q == iplk_pkg::LNK_RDOUT) begin
                ocnt_q <= ocnt_q + 3'h1;
                if (next_load) begin
                    obyte_q <= out_next; // R7
                    if (!addr_q[iplk_pkg::ADDR_TOP_BIT]) begin
                        oaddr_q <= oaddr_q + 4'h1;
                    end
                end
            end
        end
    end

    // serial output; floats whenever deselected
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            spi_q    <= 1'b0;
            spi_q_oe <= 1'b0;
        end else if (ce) begin
            spi_q_oe <= !s_sy_q[1] && st_q == iplk_pkg::LNK_RDOUT; // R17
            if (c_fall && st_q == iplk_pkg::LNK_RDOUT) begin
                spi_q <= obyte_q[3'h7 - ocnt_q];
            end
        end
    end

    // accepted only when deselect lands on a byte boundary
    assign start_ok = s_rise && st_q == iplk_pkg::LNK_WDATA
                      && bit_cnt_q == 3'h0 && any_data_q // R11
                      && !wa_q && bp_q != iplk_pkg::BP_ALL && wl_q // R4
                      && (addr_q[iplk_pkg::ADDR_TOP_BIT] ? seal_ok_q
                                                         : !locked_q); // R13
    assign tw_done  = wa_q && tw_cnt_q == '0;

    // bus address-phase capture
    logic       ahb_wr_q;
    logic [7:0] ahb_addr_q;
    logic       ahb_take;
    logic [31:0] rd_mux;

    assign ahb_take = hsel && hready && htrans[iplk_pkg::HTRANS_ACT_BIT];

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (haddr[7:0])
            iplk_pkg::ADDR_CTRL: begin
                rd_mux[iplk_pkg::CTRL_WL_BIT]   = wl_q;
                rd_mux[iplk_pkg::CTRL_BPLO_BIT] = bp_q[0];
                rd_mux[iplk_pkg::CTRL_BPHI_BIT] = bp_q[1];
            end
            iplk_pkg::ADDR_STAT: begin
                rd_mux[iplk_pkg::STAT_WL_BIT]   = wl_q;
                rd_mux[iplk_pkg::STAT_WA_BIT]   = wa_q;
                rd_mux[iplk_pkg::STAT_LOCK_BIT] = locked_q;
                rd_mux[iplk_pkg::STAT_BPLO_BIT] = bp_q[0];
                rd_mux[iplk_pkg::STAT_BPHI_BIT] = bp_q[1];
                rd_mux[iplk_pkg::STAT_FIX_BIT]  = fix_q;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ahb_wr_q   <= 1'b0;
            ahb_addr_q <= 8'h00;
            hrdata     <= 32'h0000_0000;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
        end else if (ce) begin
            // zero wait states; only whole-word writes are taken
            ahb_wr_q   <= ahb_take && hwrite && hsize == iplk_pkg::HSIZE_WORD;
            ahb_addr_q <= haddr[7:0];
            if (ahb_take && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    logic ahb_ctrl_wr, ahb_stat_wr, ahb_fault_wr;
    assign ahb_ctrl_wr  = ahb_wr_q && ahb_addr_q == iplk_pkg::ADDR_CTRL;
    assign ahb_stat_wr  = ahb_wr_q && ahb_addr_q == iplk_pkg::ADDR_STAT;
    assign ahb_fault_wr = ahb_wr_q && ahb_addr_q == iplk_pkg::ADDR_FAULT;

    // volatile flags and the write-cycle timer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin // R15
            wl_q     <= 1'b0;
            wa_q     <= 1'b0;
            seal_q   <= 1'b0;
            fix_q    <= 1'b0;
            tw_cnt_q <= '0;
        end else if (ce) begin
            if (ahb_ctrl_wr && hwdata[iplk_pkg::CTRL_WL_BIT]) begin
                wl_q <= 1'b1;
            end else if (tw_done) begin
                wl_q <= 1'b0;
            end
            if (fix_evt) begin
                fix_q <= 1'b1;
            end else if (ahb_stat_wr && hwdata[iplk_pkg::STAT_FIX_BIT]) begin
                fix_q <= 1'b0;
            end
            if (start_ok) begin // R3 R12
                wa_q     <= 1'b1;
                seal_q   <= addr_q[iplk_pkg::ADDR_TOP_BIT];
                tw_cnt_q <= TW_W'(PROG_CYCLES - 1);
            end else if (tw_done) begin
                wa_q <= 1'b0;
            end else if (wa_q) begin
                tw_cnt_q <= tw_cnt_q - 1'b1;
            end
        end
    end

    // nonvolatile cells: survive the power-on clear
    always_ff @(posedge hclk or negedge nv_resetn) begin
        if (!nv_resetn) begin // R19
            locked_q <= 1'b0;
            bp_q     <= 2'h0;
            for (int i = 0; i < iplk_pkg::PAGE_BYTES; i++) begin
                mem_q[i] <= iplk_pkg::ecc_enc(i < iplk_pkg::ID_CODE_BYTES
                    ? ID_CODE[8 * (iplk_pkg::ID_CODE_BYTES - 1 - i) +: 8]
                    : iplk_pkg::SHIPPED_BYTE);
            end
        end else if (ce) begin
            if (ahb_ctrl_wr && !wa_q) begin
                bp_q <= {hwdata[iplk_pkg::CTRL_BPHI_BIT],
                         hwdata[iplk_pkg::CTRL_BPLO_BIT]};
            end
            if (ahb_fault_wr) begin
                // test hook: flips one stored cell so correction is exercised
                mem_q[hwdata[iplk_pkg::FAULT_IDX_LSB +: 4]]
                     [hwdata[iplk_pkg::FAULT_BIT_LSB +: 4]] <=
                    ~mem_q[hwdata[iplk_pkg::FAULT_IDX_LSB +: 4]]
                          [hwdata[iplk_pkg::FAULT_BIT_LSB +: 4]];
            end
            for (int i = 0; i < iplk_pkg::PAGE_BYTES; i++) begin
                if (start_ok && !addr_q[iplk_pkg::ADDR_TOP_BIT] && wmask_q[i]) begin
                    mem_q[i] <= '0; // R20
                end else if (tw_done && !seal_q && wmask_q[i]) begin
                    mem_q[i] <= iplk_pkg::ecc_enc(wbuf_q[i]); // R20
                end
            end
            if (tw_done && seal_q) begin
                locked_q <= 1'b1; // R13
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking

    property p_hiz;
        disable iff (!hresetn) s_sy_q[1] && ce |=> !spi_q_oe;
    endproperty
    a_hiz: assert property (p_hiz) else $error("output driven while idle"); // R17
    property p_tw_load;
        disable iff (!hresetn) start_ok && ce |=> wa_q && tw_cnt_q == TW_W'(PROG_CYCLES - 1);
    endproperty
    a_tw_load: assert property (p_tw_load) else $error("timer not loaded"); // R3
    property p_tw_end;
        disable iff (!hresetn) tw_done && ce |=> !wa_q;
    endproperty
    a_tw_end: assert property (p_tw_end) else $error("write cycle overran"); // R12
    property p_tw_step;
        disable iff (!hresetn)
        wa_q && tw_cnt_q != '0 && ce |=> wa_q && tw_cnt_q == $past(tw_cnt_q) - 1'b1;
    endproperty
    a_tw_step: assert property (p_tw_step) else $error("timer disturbed"); // R4
    property p_guard;
        disable iff (!hresetn || !nv_resetn)
        $rose(wa_q) |-> $past(bp_q) != iplk_pkg::BP_ALL && $past(wl_q);
    endproperty
    a_guard: assert property (p_guard) else $error("guarded write started"); // R4
    property p_lock_byte;
        disable iff (!hresetn)
        st_q == iplk_pkg::LNK_RDOUT && addr_q[iplk_pkg::ADDR_TOP_BIT] |-> obyte_q == lock_byte;
    endproperty
    a_lock_byte: assert property (p_lock_byte) else $error("bad lock byte"); // R6
    property p_rd_busy;
        disable iff (!hresetn) first_load == 1'b0 && c_rise && !s_sy_q[1] && ce
        && st_q == iplk_pkg::LNK_ADDR && bit_cnt_q == 3'h7 && is_rd_q
        |=> st_q == iplk_pkg::LNK_SKIP;
    endproperty
    a_rd_busy: assert property (p_rd_busy) else $error("read taken while busy"); // R8
    property p_lock_perm;
        disable iff (!nv_resetn) locked_q |=> locked_q;
    endproperty
    a_lock_perm: assert property (p_lock_perm) else $error("lock lost"); // R13
    property p_poc;
        disable iff (!nv_resetn) !$past(hresetn) |-> !wl_q && !wa_q;
    endproperty
    a_poc: assert property (p_poc) else $error("flags set after clear"); // R15

    c_idwr: cover property (disable iff (!hresetn) tw_done && !seal_q);
    c_seal: cover property (disable iff (!hresetn) tw_done && seal_q);
    c_lockrd: cover property (disable iff (!hresetn) next_load && load_lock);
    c_fix: cover property (disable iff (!hresetn) fix_evt);
endmodule // iplk_top
`default_nettype wire

// [bench/iplk_spi_master.sv]
`timescale 1ns/100ps
`default_nettype none
module iplk_spi_master (
    input  wire logic hclk,
    output var  logic spi_s_n,
    output var  logic spi_c,
    output var  logic spi_d,
    input  wire logic spi_q,
    input  wire logic spi_q_oe
);
    logic q_last;

    initial begin
        spi_s_n = 1'b1;
        spi_c   = 1'b0;
        spi_d   = 1'b0;
        q_last  = 1'b0;
    end

    // 160 ns link clock, still between frames
    task automatic half();
        repeat (8) @(posedge hclk);
    endtask

    // mode 0: drive while low, sample at the rise
    task automatic bit_io(input logic b, output logic q);
        spi_d <= b;
        half();
        spi_c <= 1'b1;
        // released line shows the inverse, not a stale level
        q = spi_q_oe ? spi_q : ~q_last;
        q_last = q;
        half();
        spi_c <= 1'b0;
    endtask

    task automatic frame(input logic [7:0] op, ad, input logic [15:0] wd,
                         input int nwr, nrd, extra,
                         output logic [15:0] rd, output logic oe_seen);
        logic        q;
        logic [47:0] sh;
        int          n;
        sh = {op, ad, wd, 16'h0000};
        n = 16 + 8 * nwr + 8 * nrd + extra;
        rd = 16'h0000;
        oe_seen = 1'b0;
        spi_s_n <= 1'b0;
        half();
        for (int i = 0; i < n; i++) begin
            bit_io(sh[47 - i], q);
            if (i >= 16 + 8 * nwr) begin
                rd = {rd[14:0], q};
            end
            oe_seen = oe_seen | spi_q_oe;
        end
        half();
        spi_s_n <= 1'b1;
        repeat (8) @(posedge hclk);
    endtask
endmodule // iplk_spi_master
`default_nettype wire

// [bench/iplk_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module iplk_bench;
    localparam logic [23:0] ID   = 24'h5A_5AC3; // arbitrary value
    localparam logic [7:0]  WOP  = 8'hA2;
    localparam logic [7:0]  ROP  = 8'hA3;
    localparam logic [31:0] CTRL = 32'(iplk_pkg::ADDR_CTRL);
    localparam logic [31:0] STAT = 32'(iplk_pkg::ADDR_STAT);
    localparam logic [31:0] FLT  = 32'(iplk_pkg::ADDR_FAULT);
    logic        hclk;
    logic        hresetn;
    logic        nv_resetn;
    logic        hsel;
    logic        hwrite;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        spi_s_n;
    logic        spi_c;
    logic        spi_d;
    logic        spi_q;
    logic        spi_q_oe;
    logic [15:0] lrd;
    logic        loe;
    logic [31:0] r;
    int          n_fail;
    int          n_tests;

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // write cycle must outlast one read header (~270 cycles) for the case
    iplk_top #(.PROGRAM_TIME_US(5), .WRITE_OP(WOP), .READ_OP(ROP),
               .ID_CODE(ID)) u_iplk_top (
        .hclk(hclk), .hresetn(hresetn), .nv_resetn(nv_resetn), .ce(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .spi_s_n(spi_s_n), .spi_c(spi_c), .spi_d(spi_d), .spi_q(spi_q),
        .spi_q_oe(spi_q_oe));

    iplk_spi_master u_iplk_spi_master (
        .hclk(hclk), .spi_s_n(spi_s_n), .spi_c(spi_c), .spi_d(spi_d),
        .spi_q(spi_q), .spi_q_oe(spi_q_oe));

    task automatic chk(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t word got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chkb(input logic [7:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t link byte got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic ahb(input logic w, input logic [31:0] a, d);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= w;
        hsize  <= iplk_pkg::HSIZE_WORD;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
        chk({31'h0, hresp}, 32'h0000_0000);
    endtask

    task automatic rd(input logic [31:0] a, exp);
        ahb(1'b0, a, 32'h0000_0000);
        chk(r, exp);
    endtask

    task automatic spi(input logic [7:0] op, ad, input logic [15:0] wd,
                       input int nwr, nrd, extra);
        u_iplk_spi_master.frame(op, ad, wd, nwr, nrd, extra, lrd, loe);
    endtask

    // bounded poll; one program time is 500 cycles here
    task automatic wait_idle();
        for (int k = 0; k < 400; k++) begin
            ahb(1'b0, STAT, 32'h0000_0000);
            if (r[iplk_pkg::STAT_WA_BIT] === 1'b0) break;
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // whole sequence is about 7.6k cycles; about eight times that is a hang
    initial begin
        #600_000;
        n_fail++;
        complete_run();
    end

    initial begin
        n_fail = 0;
        n_tests = 0;
        hresetn = 1'b0;
        nv_resetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = iplk_pkg::HSIZE_WORD;
        hwdata = 32'h0000_0000;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        nv_resetn <= 1'b1;
        @(posedge hclk);
        rd(STAT, 32'h0000_0000);
        rd(32'h0000_000C, 32'h0000_0000);
        spi(ROP, 8'h00, 16'h0000, 0, 2, 0);
        chk({16'h0000, lrd}, {16'h0000, ID[23:8]});
        spi(ROP, 8'h02, 16'h0000, 0, 2, 0);
        chk({16'h0000, lrd}, {16'h0000, ID[7:0], 8'hFF});
        spi(ROP, 8'h80, 16'h0000, 0, 2, 0);
        chkb(lrd[15:8], lrd[7:0]);
        chkb({7'h00, lrd[0]}, 8'h00);
        chkb({7'h00, spi_q_oe}, 8'h00);
        ahb(1'b1, CTRL, 32'h0000_0007);
        spi(WOP, 8'h05, 16'h1100, 1, 0, 0);
        rd(STAT, 32'h0000_0031);
        ahb(1'b1, CTRL, 32'h0000_0001);
        spi(WOP, 8'h73, 16'h3C5A, 2, 0, 0);
        rd(STAT, 32'h0000_0003);
        spi(ROP, 8'h80, 16'h0000, 0, 1, 0);
        chkb({7'h00, loe}, 8'h00);
        wait_idle();
        rd(STAT, 32'h0000_0000);
        spi(ROP, 8'h02, 16'h0000, 0, 2, 0);
        chk({16'h0000, lrd}, {16'h0000, ID[7:0], 8'h3C});
        spi(ROP, 8'h04, 16'h0000, 0, 2, 0);
        chk({16'h0000, lrd}, 32'h0000_5AFF);
        ahb(1'b1, FLT, 32'h0000_0053);
        spi(ROP, 8'h03, 16'h0000, 0, 1, 0);
        chkb(lrd[7:0], 8'h3C);
        rd(STAT, 32'h0000_0040);
        ahb(1'b1, STAT, 32'h0000_0040);
        rd(STAT, 32'h0000_0000);
        ahb(1'b1, CTRL, 32'h0000_0001);
        spi(WOP, 8'h80, 16'h0200, 1, 0, 3);
        rd(STAT, 32'h0000_0001);
        spi(WOP, 8'h80, 16'hFD00, 1, 0, 0);
        rd(STAT, 32'h0000_0001);
        spi(WOP, 8'h80, 16'h0200, 1, 0, 0);
        rd(STAT, 32'h0000_0003);
        wait_idle();
        rd(STAT, 32'h0000_0004);
        spi(ROP, 8'h80, 16'h0000, 0, 1, 0);
        chkb({7'h00, lrd[0]}, 8'h01);
        ahb(1'b1, CTRL, 32'h0000_0001);
        spi(WOP, 8'h03, 16'h0000, 1, 0, 0);
        rd(STAT, 32'h0000_0005);
        spi(ROP, 8'h03, 16'h0000, 0, 1, 0);
        chkb(lrd[7:0], 8'h3C);
        ahb(1'b1, CTRL, 32'h0000_0002);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(STAT, 32'h0000_0014);
        complete_run();
    end
endmodule // iplk_bench
`default_nettype wire
